// ==== verilog/underflow_params.svh ====
// Offsets, field positions, reset values and counts for the underflow status block
`ifndef UNDERFLOW_PARAMS_SVH
`define UNDERFLOW_PARAMS_SVH
`define SEQ_COUNT 4
`define FLAGS_OFFSET 8'h18
`define MASK_OFFSET 8'h1C
`define RIS_OFFSET 8'h24
`define FLAGS_RESET 4'h0
`define MASK_RESET 4'h0
`define FLAG_LSB 0
`define FLAG_MSB 3
`endif

// ==== verilog/underflow_pkg.sv ====
// Types shared by the underflow status block
package underflow_pkg;
  typedef logic [3:0] seq_vec_t;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
endpackage

// ==== verilog/underflow_status.sv ====
// Sequencer result FIFO underflow status with Wishbone access and interrupt
// Operation
// - One flag per sequencer FIFO, bits 0-3
// - Read of empty FIFO sets its flag
// - Empty read: pointers held, zero data returned
// - Writing one clears that flag only
// - Flags reset zero; bits 31:4 read-only zero
//
// Chosen here: the Wishbone register port.
`include "underflow_params.svh"

module underflow_status
  import underflow_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // FIFO side
  input wire seq_vec_t fifo_empty_i,
  input wire seq_vec_t fifo_rd_req_i,
  output seq_vec_t fifo_pop_o,
  output logic zero_data_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_vec_t flags, next_flags;
  seq_vec_t mask, next_mask;
  seq_vec_t pop, next_pop;
  logic zero_data, next_zero_data;
  logic irq, next_irq;
  logic ack, next_ack;
  bus_state_t state, next_state;
  logic [31:0] rdata, next_rdata;
  // Plain decodes, kept as signals so that the assertions can watch them
  seq_vec_t under;
  logic wr_hit;

  // Word read for a given offset; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] adr, input seq_vec_t f,
                                            input seq_vec_t m);
    read_word = 32'h0000_0000;
    if (adr == `FLAGS_OFFSET) read_word = {28'h000_0000, f};
    else if (adr == `MASK_OFFSET) read_word = {28'h000_0000, m};
    else if (adr == `RIS_OFFSET) read_word = {28'h000_0000, f & m};
  endfunction

  // ----------------------------------------------------------------
  // FIFO side
  // ----------------------------------------------------------------
  // Underflow detection; only a non-empty FIFO is ever popped, so an empty
  // read leaves both of its pointers where they were
  always_comb
  begin
    under = fifo_rd_req_i & fifo_empty_i;
    next_pop = fifo_rd_req_i & ~fifo_empty_i;
    next_zero_data = |under;
  end

  // Pop and zero-data strobes stand for exactly one cycle per request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pop <= 4'h0;
      zero_data <= 1'b0;
    end
    else
    begin
      pop <= next_pop;
      zero_data <= next_zero_data;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, mask and interrupt
  // ----------------------------------------------------------------
  // Clear first, then set, so an underflow in the clearing cycle survives
  always_comb
  begin
    wr_hit = (state == BUS_IDLE) && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0];
    next_flags = flags;
    next_mask = mask;
    if (wr_hit && wb_i.adr == `FLAGS_OFFSET)
    begin
      next_flags = flags & ~wb_i.dat[`FLAG_MSB:`FLAG_LSB];
    end
    if (wr_hit && wb_i.adr == `MASK_OFFSET)
    begin
      next_mask = wb_i.dat[`FLAG_MSB:`FLAG_LSB];
    end
    next_flags = next_flags | under;
    // Built from the values being loaded, so irq moves on the same edge as the flags
    next_irq = |(next_flags & next_mask);
  end

  // Flags and mask; bits 31:4 have no storage, so writes there cannot land
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags <= `FLAGS_RESET;
      mask <= `MASK_RESET;
      irq <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One request is taken per idle cycle; the ack state refuses a second take
  // while the master still holds the request that it is about to release
  always_comb
  begin
    next_state = state;
    next_ack = 1'b0;
    next_rdata = rdata;
    unique case (state)
      BUS_IDLE:
        if (wb_i.cyc && wb_i.stb)
        begin
          next_state = BUS_ACK;
          next_ack = 1'b1;
          next_rdata = read_word(wb_i.adr, flags, mask);
        end
      BUS_ACK:
        next_state = BUS_IDLE;
    endcase
  end

  // Bus registers; ack has its own flop so the output is not a state decode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= BUS_IDLE;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output straight from a flip-flop; ack answers one cycle after the take
  // The zero-data strobe tells the FIFO read path to hand back an all-zero word
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign fifo_pop_o = pop;
  assign zero_data_o = zero_data;
  assign irq_o = irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Underflow, clear and sticky behaviour of the flags, empty-read pops and reserved read bits
  AST_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_rd_req_i[0] && fifo_empty_i[0] |=> flags[0]) else $error("flag not set");
  AST_NOPOP: assert property (@(posedge clk_i) disable iff (rst_i)
    |(fifo_rd_req_i & fifo_empty_i) |=> zero_data_o && !(|(pop & $past(fifo_empty_i))))
    else $error("empty read popped or returned data");
  AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit && wb_i.adr == `FLAGS_OFFSET && wb_i.dat[1] && !under[1] |=> !flags[1])
    else $error("flag not cleared");
  AST_OTHERS: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit && wb_i.adr == `FLAGS_OFFSET && !wb_i.dat[2] && flags[2] |=> flags[2])
    else $error("other flag disturbed");
  AST_RSV: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:4] == 28'h000_0000) else $error("reserved bits nonzero");
  AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[3] && !(wr_hit && wb_i.adr == `FLAGS_OFFSET && wb_i.dat[3]) |=> flags[3])
    else $error("flag dropped");
  AST_WIN: assert property (@(posedge clk_i) disable iff (rst_i)
    under[0] && wr_hit && wb_i.adr == `FLAGS_OFFSET |=> flags[0])
    else $error("set lost to clear");
  // Reset leaves every flag and mask bit clear; checked on the first edge
  // after release, so that a reset in mid-run is covered as well
  AST_RST_ZERO: assert property (@(posedge clk_i)
    $fell(rst_i) |-> flags == `FLAGS_RESET && mask == `MASK_RESET)
    else $error("flags or mask not zero after reset");
  // Zero data and pops only ever follow the matching kind of read request
  AST_ZERO_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    zero_data_o |-> |($past(fifo_rd_req_i) & $past(fifo_empty_i)))
    else $error("zero data without an empty read");
  AST_POP_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_pop_o == ($past(fifo_rd_req_i) & ~$past(fifo_empty_i)))
    else $error("pop does not match the read requests");
  // An unmasked underflow raises the interrupt on the next cycle
  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    |(under & mask) && !(wr_hit && wb_i.adr == `MASK_OFFSET) |=> irq_o)
    else $error("interrupt not raised");
  // Bus handshake: a request seen while idle is answered next cycle, once
  AST_TAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o && wb_i.cyc && wb_i.stb |=> wb_ack_o)
    else $error("request not answered");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  // Main scenarios: underflow, clear, race of the two, pop and interrupt
  COV_UF: cover property (@(posedge clk_i) under[2]);
  COV_CLR: cover property (@(posedge clk_i) wr_hit && wb_i.adr == `FLAGS_OFFSET);
  COV_IRQ: cover property (@(posedge clk_i) irq_o);
  COV_RACE: cover property (@(posedge clk_i) under[0] && wr_hit && wb_i.adr == `FLAGS_OFFSET);
  COV_POP: cover property (@(posedge clk_i) fifo_pop_o == 4'hF);

endmodule // underflow_status

// ==== verif/tb_top.sv ====
// Self-checking bench for the sequencer FIFO underflow status block
module tb_top
  import underflow_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_i = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, zero_data_o, irq_o;
  seq_vec_t fifo_empty_i = '0, fifo_rd_req_i = '0, fifo_pop_o;
  int err_count = 0, checked = 0;
  logic [3:0] wb_sel = 4'hF;
  always #4 clk_i = ~clk_i;
  underflow_status underflow_status_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fifo_empty_i(fifo_empty_i),
    .fifo_rd_req_i(fifo_rd_req_i), .fifo_pop_o(fifo_pop_o), .zero_data_o(zero_data_o),
    .irq_o(irq_o));
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic single cycle; request held until ack is sampled, bounded wait
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{adr: a, dat: d, sel: wb_sel, we: w, cyc: 1'b1, stb: 1'b1};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 16);
    q = wb_dat_o;
    wb_i <= '0;
    if (n >= 16)
    begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic rdf(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk("register", q, e);
  endtask
  // One read pulse per sequencer; pop and zero data seen one cycle later
  task automatic rd(input seq_vec_t e, r);
    @(posedge clk_i);
    fifo_empty_i <= e;
    fifo_rd_req_i <= r;
    @(posedge clk_i);
    fifo_rd_req_i <= '0;
    #1;
    chk("pop", 32'(fifo_pop_o), 32'(r & ~e));
    chk("zero_data", 32'(zero_data_o), 32'(|(r & e)));
  endtask
  task automatic sc_reset();
    rdf(8'h18, 32'h0);
    rdf(8'h1C, 32'h0);
  endtask
  task automatic sc_set();
    for (int i = 0; i < 4; i++)
    begin
      rd(4'hF, seq_vec_t'(1 << i));
      rdf(8'h18, (32'h2 << i) - 32'h1);
    end
    rd(4'h0, 4'hF);
    rdf(8'h18, 32'hF);
  endtask
  task automatic sc_clear();
    wb(8'h18, 1'b1, 32'hFFFF_FFF0);
    rdf(8'h18, 32'hF);
    wb(8'h18, 1'b1, 32'h4);
    rdf(8'h18, 32'hB);
  endtask
  task automatic sc_irq();
    chk("irq", 32'(irq_o), 32'h0);
    wb(8'h1C, 1'b1, 32'h2);
    rdf(8'h1C, 32'h2);
    rdf(8'h24, 32'h2);
    chk("irq", 32'(irq_o), 32'h1);
    wb(8'h18, 1'b1, 32'h2);
    rdf(8'h18, 32'h9);
    chk("irq", 32'(irq_o), 32'h0);
  endtask
  // Underflow and clear of the same flag land on one edge: the set must win
  task automatic sc_race();
    fork
      wb(8'h18, 1'b1, 32'h1);
      rd(4'h1, 4'h1);
    join
    rdf(8'h18, 32'h9);
    wb(8'h30, 1'b1, 32'hF);
    rdf(8'h30, 32'h0);
    rdf(8'h18, 32'h9);
    // A write with sel bit 0 low is acked but not applied, and must clear nothing
    wb_sel = 4'h0;
    wb(8'h18, 1'b1, 32'hF);
    wb_sel = 4'hF;
    rdf(8'h18, 32'h9);
  endtask
  // Reset in mid-run: flags, mask and interrupt all return to zero
  task automatic sc_rst();
    wb(8'h1C, 1'b1, 32'h8);
    chk("irq", 32'(irq_o), 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq", 32'(irq_o), 32'h0);
    rdf(8'h18, 32'h0);
    rdf(8'h1C, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_set();
    sc_clear();
    sc_irq();
    sc_race();
    sc_rst();
    end_sim();
  end
endmodule // tb_top
